// File: pcth_pkg.sv
// Purpose: Shared constants and carrier types for the configuration header timer/base block
// Assumes: Configuration access is a simplified dword port on the PCI clock
// Notes: Offsets are byte addresses of the configuration header
//
// Summary of operation
// - Latency limit, bits 15:8 at offset 0Ch, writable, counted in clocks.
// - Counter restarts at zero on own FRAME assertion, advances each clock until it reaches the limit.
// - Limit reached before transaction ends: terminate once GNT is deasserted.
// - Writable line burst length, bits 7:0 at 0Ch, used for line commands.
// - Self-test byte at 0Eh bits 15:8 reads 00h.
// - Header layout byte at 0Eh bits 7:0 reads 00h.
// - Base bits 31:11 at offset 10h writable, hold window address.
// - Base bits 10:4 read zero, meaning a 2K window.
// - Base bit 3 reads zero: not prefetchable.
// - Base bits 2:1 read zero: 32-bit decode anywhere.
// - Base bit 0 reads zero: memory space.
// - All-ones write reads back FFFF F800h.
package pcth_pkg;
  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam logic [7:0] PCTH_OFS_TIMER_LINE = 8'h0c;
  localparam logic [7:0] PCTH_OFS_HDR_SELFTEST = 8'h0e;
  localparam logic [7:0] PCTH_OFS_WIN_BASE = 8'h10;
  localparam logic [5:0] PCTH_DW_0C = 6'h03;
  localparam logic [5:0] PCTH_DW_10 = 6'h04;
  localparam logic [7:0] PCTH_TIMER_RST = 8'h00;
  localparam logic [7:0] PCTH_LINE_RST = 8'h00;
  localparam logic [7:0] PCTH_SELFTEST_VAL = 8'h00;
  localparam logic [7:0] PCTH_HDR_LAYOUT_VAL = 8'h00;
  localparam logic [20:0] PCTH_BASE_RST = 21'h000000;
  localparam int PCTH_BASE_LSB = 11;
  localparam logic [6:0] PCTH_WINDOW_SIZE_BITS = 7'h00;
  localparam logic PCTH_WINDOW_PREFETCH_FLAG = 1'h0;
  localparam logic [1:0] PCTH_WINDOW_DECODE_WIDTH = 2'h0;
  localparam logic PCTH_WINDOW_SPACE_SELECT = 1'h0;
  localparam logic [31:0] PCTH_BASE_SIZING_VAL = 32'hfffff800;

  // ********************************************************************
  // Carrier types
  // ********************************************************************
  typedef struct packed {
    logic rd;
    logic wr;
    logic [5:0] dw_addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } pcth_cfg_req_s;

  typedef struct packed {
    logic [20:0] window_base_upper;
    logic [6:0] window_size_bits;
    logic window_prefetch_flag;
    logic [1:0] window_decode_width;
    logic window_space_select;
  } pcth_bar_s;

  typedef enum logic [1:0] {
    PCTH_IDLE = 2'b00,
    PCTH_BUSY = 2'b01,
    PCTH_EXPIRED = 2'b10
  } pcth_tenure_e;
endpackage : pcth_pkg

// File: pcth_tenure.sv
// Purpose: Initiator tenure counter with latency limit
// Assumes: frame_start_in pulses on the clock the device asserts FRAME
// Notes: Termination request waits for GNT deassertion after expiry
`timescale 1ns/10ps
module pcth_tenure (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] limit_in,
  input wire logic frame_start_in,
  input wire logic xfer_done_in,
  input wire logic gnt_n_in,
  output logic expired_out,
  output logic terminate_out
);
  import pcth_pkg::*;

  pcth_tenure_e state_ff, nxt_state;
  logic [7:0] count_ff;
  logic [7:0] nxt_count;
  logic term_ff;
  wire reached = (count_ff >= limit_in);

  // ********************************************************************
  // Counter and state
  // ********************************************************************
  assign nxt_count = frame_start_in ? 8'h00 :
                     (state_ff == PCTH_BUSY && !reached) ? count_ff + 8'h01 : count_ff;

  always_comb begin
    case (state_ff)
      PCTH_IDLE: nxt_state = frame_start_in ? PCTH_BUSY : PCTH_IDLE;
      PCTH_BUSY: begin
        if (xfer_done_in) nxt_state = PCTH_IDLE;
        else if (reached) nxt_state = PCTH_EXPIRED;
        else nxt_state = PCTH_BUSY;
      end
      PCTH_EXPIRED: nxt_state = (xfer_done_in || gnt_n_in) ? PCTH_IDLE : PCTH_EXPIRED;
      default: nxt_state = PCTH_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_ff <= PCTH_IDLE;
      count_ff <= 8'h00;
      term_ff <= 1'b0;
    end else begin
      state_ff <= frame_start_in ? PCTH_BUSY : nxt_state;
      count_ff <= nxt_count;
      // Own transaction still open and grant withdrawn after expiry
      term_ff <= (state_ff == PCTH_EXPIRED) && gnt_n_in && !xfer_done_in;
    end
  end

  assign expired_out = (state_ff == PCTH_EXPIRED);
  assign terminate_out = term_ff;

  a_restart_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    frame_start_in |=> count_ff == 8'h00)
    else $error("tenure count not restarted");
  a_count_advance: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_ff == PCTH_BUSY && !reached && !frame_start_in |=> count_ff == $past(count_ff) + 8'h01)
    else $error("tenure count did not advance");
  a_expire_entry: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_ff == PCTH_BUSY && reached && !xfer_done_in && !frame_start_in |=> expired_out)
    else $error("limit reached without expiry");
  a_term_after_gnt: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    terminate_out |-> $past(gnt_n_in) && $past(expired_out))
    else $error("termination without expiry and grant loss");
endmodule : pcth_tenure

// File: pcth_config_regs.sv
// Purpose: Configuration header offsets 0Ch..13h and memory window decode
// Assumes: Config port gives dword index, byte enables, one-cycle rd/wr strobes
// Notes: Read data registered one cycle after the strobe
`timescale 1ns/10ps
module pcth_config_regs (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire pcth_pkg::pcth_cfg_req_s cfg_req_in,
  input wire logic mem_cmd_in,
  input wire logic [31:0] mem_addr_in,
  input wire logic frame_start_in,
  input wire logic xfer_done_in,
  input wire logic gnt_n_in,
  output logic [31:0] cfg_rdata_out,
  output logic cfg_rvalid_out,
  output logic [7:0] line_burst_length_out,
  output logic [20:0] window_base_upper_out,
  output logic win_hit_out,
  output logic tenure_expired_out,
  output logic terminate_out
);
  import pcth_pkg::*;

  logic [7:0] timer_ff;
  logic [7:0] line_ff;
  logic [20:0] base_ff;
  logic [31:0] rdata_ff;
  logic rvalid_ff;
  logic hit_ff;
  logic exp_w;
  logic term_w;
  logic exp_ff;
  logic term_ff;

  function automatic logic dw_sel(input pcth_cfg_req_s r, input logic [5:0] dw);
    dw_sel = (r.dw_addr == dw);
  endfunction : dw_sel

  // ********************************************************************
  // Decode and read mux
  // ********************************************************************
  wire sel_0c = dw_sel(cfg_req_in, PCTH_DW_0C);
  wire sel_10 = dw_sel(cfg_req_in, PCTH_DW_10);
  wire wr_0c = cfg_req_in.wr && sel_0c;
  wire wr_10 = cfg_req_in.wr && sel_10;
  pcth_bar_s bar_view;
  assign bar_view.window_base_upper = base_ff;
  assign bar_view.window_size_bits = PCTH_WINDOW_SIZE_BITS;
  assign bar_view.window_prefetch_flag = PCTH_WINDOW_PREFETCH_FLAG;
  assign bar_view.window_decode_width = PCTH_WINDOW_DECODE_WIDTH;
  assign bar_view.window_space_select = PCTH_WINDOW_SPACE_SELECT;
  // Upper half of dword 0Ch is read-only layout and self-test
  wire [31:0] dw0c_val = {PCTH_SELFTEST_VAL, PCTH_HDR_LAYOUT_VAL, timer_ff, line_ff};
  wire [31:0] nxt_rdata = sel_0c ? dw0c_val : sel_10 ? bar_view : 32'h00000000;
  // Decode on upper 21 bits only: 2K window
  wire nxt_hit = mem_cmd_in && (mem_addr_in[31:PCTH_BASE_LSB] == base_ff);

  // ********************************************************************
  // Storage
  // ********************************************************************
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      timer_ff <= PCTH_TIMER_RST;
      line_ff <= PCTH_LINE_RST;
      base_ff <= PCTH_BASE_RST;
    end else begin
      if (wr_0c && cfg_req_in.be[1]) timer_ff <= cfg_req_in.wdata[15:8];
      if (wr_0c && cfg_req_in.be[0]) line_ff <= cfg_req_in.wdata[7:0];
      // Lane 1 carries only base bits 15:11; its low three bits are read-only
      if (wr_10 && cfg_req_in.be[1]) base_ff[4:0] <= cfg_req_in.wdata[15:11];
      if (wr_10 && cfg_req_in.be[2]) base_ff[12:5] <= cfg_req_in.wdata[23:16];
      if (wr_10 && cfg_req_in.be[3]) base_ff[20:13] <= cfg_req_in.wdata[31:24];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata_ff <= 32'h00000000;
      rvalid_ff <= 1'b0;
      hit_ff <= 1'b0;
      exp_ff <= 1'b0;
      term_ff <= 1'b0;
    end else begin
      rdata_ff <= cfg_req_in.rd ? nxt_rdata : 32'h00000000;
      rvalid_ff <= cfg_req_in.rd;
      hit_ff <= nxt_hit;
      exp_ff <= exp_w;
      term_ff <= term_w;
    end
  end

  pcth_tenure u_tenure (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .limit_in(timer_ff),
    .frame_start_in(frame_start_in),
    .xfer_done_in(xfer_done_in),
    .gnt_n_in(gnt_n_in),
    .expired_out(exp_w),
    .terminate_out(term_w)
  );

  assign cfg_rdata_out = rdata_ff;
  assign cfg_rvalid_out = rvalid_ff;
  assign line_burst_length_out = line_ff;
  assign window_base_upper_out = base_ff;
  assign win_hit_out = hit_ff;
  assign tenure_expired_out = exp_ff;
  assign terminate_out = term_ff;

  // ********************************************************************
  // Checks
  // ********************************************************************
  a_timer_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_0c && cfg_req_in.be[1] |=> timer_ff == $past(cfg_req_in.wdata[15:8]))
    else $error("latency limit not written");
  a_line_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_0c && cfg_req_in.be[0] |=> line_burst_length_out == $past(cfg_req_in.wdata[7:0]))
    else $error("line length not written");
  a_upper_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cfg_req_in.rd && sel_0c |=> cfg_rdata_out[31:24] == 8'h00)
    else $error("self-test byte not zero");
  a_layout_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cfg_req_in.rd && sel_0c |=> cfg_rdata_out[23:16] == 8'h00)
    else $error("header layout byte not zero");
  a_base_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_10 && cfg_req_in.be == 4'hf |=> base_ff == $past(cfg_req_in.wdata[31:11]))
    else $error("window base not written");
  a_base_lane_one: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_10 && cfg_req_in.be[1] |=> base_ff[4:0] == $past(cfg_req_in.wdata[15:11]))
    else $error("base lane one not written");
  a_base_lane_top: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_10 && cfg_req_in.be[3] |=> base_ff[20:13] == $past(cfg_req_in.wdata[31:24]))
    else $error("base top lane not written");
  a_low_bits_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cfg_req_in.rd && sel_10 |=> cfg_rdata_out[10:0] == 11'h000)
    else $error("base low bits not zero");
  // Base all ones comes from a sizing write or from any writes that set all of bits 31:11
  a_sizing_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cfg_req_in.rd && sel_10 && (&base_ff) |=> cfg_rdata_out == PCTH_BASE_SIZING_VAL)
    else $error("sizing readback wrong");
  a_rvalid_pulse: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cfg_req_in.rd |=> cfg_rvalid_out)
    else $error("read answer missing");
  a_idle_rdata_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !cfg_req_in.rd |=> !cfg_rvalid_out && cfg_rdata_out == 32'h00000000)
    else $error("read answer without request");
  a_other_dw_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cfg_req_in.rd && !sel_0c && !sel_10 |=> cfg_rdata_out == 32'h00000000)
    else $error("unmapped dword not zero");
  a_window_hit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    mem_cmd_in && mem_addr_in[31:PCTH_BASE_LSB] == base_ff |=> win_hit_out)
    else $error("window access not claimed");
  a_window_miss: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    mem_cmd_in && mem_addr_in[31:PCTH_BASE_LSB] != base_ff |=> !win_hit_out)
    else $error("access outside window claimed");
  a_reset_clear: assert property (@(posedge clk_in)
    !rst_n_in |=> timer_ff == PCTH_TIMER_RST && line_ff == PCTH_LINE_RST &&
    base_ff == PCTH_BASE_RST)
    else $error("registers not cleared by reset");
endmodule : pcth_config_regs

// File: pcth_host_model.sv
// Purpose: Host bridge model issuing configuration cycles and granting the bus
// Assumes: One configuration request per call, strobe held for one clock
// Notes: Released data lines are inverted so a stale value cannot pass
`timescale 1ns/10ps
module pcth_host_model (
  input wire logic clk_in,
  input wire logic [31:0] cfg_rdata_in,
  input wire logic cfg_rvalid_in,
  output pcth_pkg::pcth_cfg_req_s cfg_req_out,
  output logic gnt_n_out
);
  import pcth_pkg::*;
  initial begin
    cfg_req_out = '0;
    gnt_n_out = 1'b0;
  end
  // Sizing and base writes go through here
  task automatic cfg_access(input logic wr, input logic [5:0] dw, input logic [3:0] be,
                            input logic [31:0] wd, output logic [31:0] rd, output logic rv);
    @(posedge clk_in);
    cfg_req_out <= '{rd: !wr, wr: wr, dw_addr: dw, be: be, wdata: wd};
    @(posedge clk_in);
    cfg_req_out <= '{rd: 1'b0, wr: 1'b0, dw_addr: ~dw, be: ~be, wdata: ~wd};
    #1;
    rd = cfg_rdata_in;
    rv = cfg_rvalid_in;
  endtask : cfg_access
  task automatic set_grant(input logic g_n);
    @(posedge clk_in);
    gnt_n_out <= g_n;
  endtask : set_grant
endmodule : pcth_host_model

// File: pcth_config_regs_tb_top.sv
// Purpose: Self-checking bench for the timer, header and window base registers
// Assumes: Host model owns the configuration port and the grant line
// Notes: Tenure limit kept small so expiry is reached quickly
`timescale 1ns/10ps
module pcth_config_regs_tb_top;
  import pcth_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic mem_cmd_in = 1'b0;
  logic [31:0] mem_addr_in = 32'h0;
  logic frame_start_in = 1'b0;
  logic xfer_done_in = 1'b0;
  pcth_cfg_req_s cfg_req;
  logic gnt_n, rvalid, hit, expired, term;
  logic [31:0] rdata;
  logic [7:0] line_len;
  logic [20:0] base_up;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  always #2.5 clk_in = ~clk_in;
  pcth_host_model u_host (.clk_in(clk_in), .cfg_rdata_in(rdata), .cfg_rvalid_in(rvalid),
    .cfg_req_out(cfg_req), .gnt_n_out(gnt_n));
  pcth_config_regs u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .cfg_req_in(cfg_req),
    .mem_cmd_in(mem_cmd_in), .mem_addr_in(mem_addr_in), .frame_start_in(frame_start_in),
    .xfer_done_in(xfer_done_in), .gnt_n_in(gnt_n), .cfg_rdata_out(rdata),
    .cfg_rvalid_out(rvalid), .line_burst_length_out(line_len),
    .window_base_upper_out(base_up), .win_hit_out(hit), .tenure_expired_out(expired),
    .terminate_out(term));
  task automatic stop_test();
    if (bad_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [5:0] dw, input logic [3:0] be, input logic [31:0] wd);
    logic [31:0] d;
    logic v;
    u_host.cfg_access(1'b1, dw, be, wd, d, v);
  endtask : wr
  task automatic rd_chk(input logic [5:0] dw, input logic [31:0] exp);
    logic [31:0] d;
    logic v;
    u_host.cfg_access(1'b0, dw, 4'hf, 32'h0, d, v);
    check({31'h0, v}, 32'h1);
    check(d, exp);
  endtask : rd_chk
  task automatic probe(input logic [31:0] a, input logic exp);
    @(posedge clk_in);
    mem_cmd_in <= 1'b1;
    mem_addr_in <= a;
    @(posedge clk_in);
    mem_cmd_in <= 1'b0;
    mem_addr_in <= ~a;
    #1;
    check({31'h0, hit}, {31'h0, exp});
  endtask : probe
  task automatic t_reset_vals();
    rd_chk(PCTH_DW_0C, 32'h0);
    rd_chk(PCTH_DW_10, 32'h0);
    rd_chk(6'h05, 32'h0);
  endtask : t_reset_vals
  task automatic t_timer_line();
    wr(PCTH_DW_0C, 4'hf, 32'hffff_a55a);
    rd_chk(PCTH_DW_0C, 32'h0000_a55a);
    check({24'h0, line_len}, 32'h5a);
  endtask : t_timer_line
  task automatic t_window();
    wr(PCTH_DW_10, 4'hf, 32'hffff_ffff);
    rd_chk(PCTH_DW_10, PCTH_BASE_SIZING_VAL);
    wr(PCTH_DW_10, 4'hf, 32'hc000_0fff);
    wr(PCTH_DW_10, 4'h1, 32'h0000_00ff);
    rd_chk(PCTH_DW_10, 32'hc000_0800);
    check({11'h0, base_up}, 32'h0018_0001);
    probe(32'hc000_0ffc, 1'b1);
    probe(32'hc000_1000, 1'b0);
    probe(32'hc000_07fc, 1'b0);
    wr(PCTH_DW_10, 4'h2, 32'h0000_f800);
    rd_chk(PCTH_DW_10, 32'hc000_f800);
    wr(PCTH_DW_10, 4'h8, 32'h5a00_0000);
    wr(PCTH_DW_10, 4'h4, 32'h00a5_0000);
    rd_chk(PCTH_DW_10, 32'h5aa5_f800);
  endtask : t_window
  task automatic t_tenure();
    int n;
    wr(PCTH_DW_0C, 4'h2, 32'h0000_0300);
    rd_chk(PCTH_DW_0C, 32'h0000_035a);
    @(posedge clk_in);
    frame_start_in <= 1'b1;
    @(posedge clk_in);
    frame_start_in <= 1'b0;
    #1;
    check({31'h0, expired}, 32'h0);
    n = 0;
    while (expired !== 1'b1 && n < 12) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    check({31'h0, expired}, 32'h1);
    check(n, 32'h5);
    check({31'h0, term}, 32'h0);
    u_host.set_grant(1'b1);
    n = 0;
    while (term !== 1'b1 && n < 6) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    check({31'h0, term}, 32'h1);
    @(posedge clk_in);
    xfer_done_in <= 1'b1;
    @(posedge clk_in);
    xfer_done_in <= 1'b0;
  endtask : t_tenure
  task automatic t_mid_reset();
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    #1;
    check({1'b0, line_len, base_up, expired, term}, 32'h0);
    rd_chk(PCTH_DW_0C, 32'h0);
    rd_chk(PCTH_DW_10, 32'h0);
  endtask : t_mid_reset
  initial begin
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    t_reset_vals();
    t_timer_line();
    t_window();
    t_tenure();
    t_mid_reset();
    stop_test();
  end
endmodule : pcth_config_regs_tb_top
